//--- rtl/ealc_top.sv
// Four-channel equalizer adaptation, boost search and lock control.
`timescale 1ns/1ps

module ealc_top (
  // Clock and reset
  input  wire logic                                      ref_clk_in,
  input  wire logic                                      nrst_in,
  // Management register port
  input  wire ealc_pkg::ealc_reg_req_s                   reg_req_in,
  output logic                        [7:0]              reg_rdata_out,
  output logic                                           reg_rvalid_out,
  // Channel analog side
  input  wire ealc_pkg::ealc_ch_in_s  [ealc_pkg::NCH-1:0] ch_in,
  output ealc_pkg::ealc_ch_out_s      [ealc_pkg::NCH-1:0] ch_out
);
  import ealc_pkg::*;

  logic [7:0] cfg      [NCH][NREG];
  logic [7:0] tbl_bus_q [NCH];
  logic [3:0] ridx;
  logic       tbl_hit;
  logic       rd1;
  logic [1:0] ch1;
  logic       tbl1;
  logic [7:0] val1;

  assign ridx    = reg_idx(reg_req_in.addr);
  assign tbl_hit = (reg_req_in.addr >= A_TBL_FIRST) && (reg_req_in.addr <= A_TBL_LAST);

  // ---------------------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      rd1  <= 1'b0;
      ch1  <= 2'b00;
      tbl1 <= 1'b0;
      val1 <= 8'h00;
    end
    else
    begin
      rd1  <= reg_req_in.rd;
      ch1  <= reg_req_in.ch;
      tbl1 <= tbl_hit;
      val1 <= (ridx != I_NONE) ? cfg[reg_req_in.ch][ridx] : 8'h00;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      reg_rvalid_out <= 1'b0;
      reg_rdata_out  <= 8'h00;
    end
    else
    begin
      reg_rvalid_out <= rd1;
      if (rd1)
        reg_rdata_out <= tbl1 ? tbl_bus_q[ch1] : val1;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel controllers
  // ---------------------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    ealc_state_e st;
    ealc_mode_e  mode;
    logic        wr_here;
    logic        soft_rst;
    logic        ph_s1, ph_s2, vc_s1, vc_s2, vc_s3;
    logic [9:0]  wcnt, tcnt, win_count, cal_count, lock_count;
    logic        win_done;
    logic        ctle_prev, dfe_prev, ctle_trig, dfe_trig, cdr_rst;
    logic [4:0]  idx, beyond, lookb;
    logic [7:0]  tbl_q, best_fom, best_boost, fom, res_val;
    logic        best_seen, pass, manual_dfe, res_wr, lol_q, restart_q;
    logic [11:0] timer;
    logic        eye_ok, better, settle_end, lock_stop, adv, tried_out, adapt_on;

    assign wr_here  = reg_req_in.wr && (reg_req_in.ch == 2'(c));
    assign soft_rst = cfg[c][I_CH_RESET][CH_RST_BIT];
    assign mode     = ealc_mode_e'(cfg[c][I_ADAPT_SEL][MODE_MSB:MODE_LSB]);
    assign adapt_on = (mode != MODE_NONE);
    assign lookb    = {1'b0, cfg[c][I_LOOK_BEY][LB_MSB:LB_LSB]};
    assign ctle_trig = ctle_prev && !cfg[c][I_RATE_TRIG][CTLE_TRIG_BIT];
    assign dfe_trig  = dfe_prev && !cfg[c][I_DFE_TRIG][DFE_TRIG_BIT];
    assign cdr_rst   = wr_here && (ridx == I_CDR_CTRL) && (reg_req_in.wdata[CDR_RST_MSB:CDR_RST_LSB] != 2'b00);

    always_comb
    begin
      fom = (ch_in[c].horizontal_eye_width < ch_in[c].vertical_eye_height) ?
            ch_in[c].horizontal_eye_width : ch_in[c].vertical_eye_height;
      eye_ok = (ch_in[c].horizontal_eye_width > {cfg[c][I_EYE_THR][THR_H_MSB:THR_H_LSB], 4'h0}) &&
               (ch_in[c].vertical_eye_height > {cfg[c][I_EYE_THR][THR_V_MSB:THR_V_LSB], 4'h0});
      better     = fom > best_fom;
      settle_end = (st == S_TRY) && (timer == SETTLE_CYC - 12'h001);
      lock_stop  = (st == S_MEAS) && ch_in[c].eye_valid && eye_ok && ph_s2 &&
                   (mode == MODE_LOCK_DFE) && !pass;
      adv        = (settle_end && !ph_s2) ||
                   ((st == S_MEAS) && ch_in[c].eye_valid && !lock_stop) ||
                   ((st == S_MEAS) && !ch_in[c].eye_valid && (timer == EYE_CYC - 12'h001));
      tried_out  = (idx == IDX_MAX) || (best_seen && (beyond + 5'h01 >= lookb));
    end

    // Phase-lock and oscillator pins pass two flip-flops; edge detection compares the second stage with a third.
    always_ff @(posedge ref_clk_in)
    begin
      if (!nrst_in)
      begin
        {ph_s1, ph_s2, vc_s1, vc_s2, vc_s3} <= 5'h00;
      end
      else
      begin
        ph_s1 <= ch_in[c].phase_lock;
        ph_s2 <= ph_s1;
        vc_s1 <= ch_in[c].vco_div;
        vc_s2 <= vc_s1;
        vc_s3 <= vc_s2;
      end
    end

    // Oscillator edges counted over a fixed reference window.
    always_ff @(posedge ref_clk_in)
    begin
      if (!nrst_in || soft_rst)
      begin
        wcnt      <= 10'h000;
        tcnt      <= 10'h000;
        win_count <= 10'h000;
        win_done  <= 1'b0;
      end
      else
      begin
        win_done <= (wcnt == WIN_CYC - 10'h001);
        if (wcnt == WIN_CYC - 10'h001)
        begin
          wcnt      <= 10'h000;
          tcnt      <= 10'h000;
          win_count <= tcnt + {9'h000, vc_s2 && !vc_s3};
        end
        else
        begin
          wcnt <= wcnt + 10'h001;
          tcnt <= tcnt + {9'h000, vc_s2 && !vc_s3};
        end
      end
    end

    // Configuration registers; the adaptation result write follows a host write.
    always_ff @(posedge ref_clk_in)
    begin
      if (!nrst_in || soft_rst)
      begin
        for (int i = 0; i < NREG; i++)
          cfg[c][i] <= CFG_RESET[i];
      end
      else
      begin
        if (wr_here && (ridx != I_NONE))
          cfg[c][ridx] <= reg_req_in.wdata;
        if (res_wr)
          cfg[c][I_BOOST_RES] <= res_val;
      end
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (!nrst_in || soft_rst)
      begin
        ctle_prev <= 1'b0;
        dfe_prev  <= 1'b0;
      end
      else
      begin
        ctle_prev <= cfg[c][I_RATE_TRIG][CTLE_TRIG_BIT];
        dfe_prev  <= cfg[c][I_DFE_TRIG][DFE_TRIG_BIT];
      end
    end

    // Adaptation and lock sequencer.
    always_ff @(posedge ref_clk_in)
    begin
      if (!nrst_in)
      begin
        st <= S_CAL;
        {idx, beyond} <= 10'h000;
        {best_fom, best_boost, res_val} <= 24'h000000;
        {best_seen, pass, manual_dfe, res_wr, lol_q, restart_q} <= 6'h00;
        timer      <= 12'h000;
        cal_count  <= 10'h000;
        lock_count <= 10'h000;
      end
      else
      begin
        res_wr    <= 1'b0;
        lol_q     <= 1'b0;
        restart_q <= 1'b0;
        case (st)
          S_CAL:
          begin
            if (win_done)
            begin
              cal_count <= win_count;
              restart_q <= 1'b1;
              st        <= adapt_on ? S_START : S_ACQ;
            end
          end
          S_ACQ:
          begin
            if (ch_in[c].eye_valid && ph_s2 && eye_ok)
            begin
              if (abs_diff(win_count, cal_count) > SPUR_TOL)
              begin
                restart_q <= 1'b1;
                pass      <= 1'b0;
                st        <= adapt_on ? S_START : S_ACQ;
              end
              else
              begin
                lock_count <= win_count;
                st         <= S_LOCK;
              end
            end
          end
          S_START:
          begin
            idx <= cfg[c][I_RATE_TRIG][START_OVR_BIT] ? cfg[c][I_START_IDX][START_MSB:0] : IDX_ZERO;
            best_fom   <= 8'h00;
            best_boost <= cfg[c][I_BOOST_RES];
            best_seen  <= 1'b0;
            beyond     <= 5'h00;
            timer      <= 12'h000;
            st         <= S_TRY;
          end
          S_TRY, S_MEAS:
          begin
            timer <= timer + 12'h001;
            if (settle_end && ph_s2)
            begin
              timer <= 12'h000;
              st    <= S_MEAS;
            end
            if (lock_stop)
            begin
              best_boost <= tbl_q;
              st         <= S_DONE;
            end
            else if (adv && ch_in[c].eye_valid && (st == S_MEAS) && better)
            begin
              best_fom   <= fom;
              best_boost <= tbl_q;
              best_seen  <= 1'b1;
              beyond     <= 5'h00;
              timer      <= 12'h000;
              idx        <= idx + 5'h01;
              st         <= (idx == IDX_MAX) ? S_DONE : S_TRY;
            end
            else if (adv)
            begin
              timer  <= 12'h000;
              beyond <= best_seen ? beyond + 5'h01 : beyond;
              idx    <= idx + 5'h01;
              st     <= tried_out ? S_DONE : S_TRY;
            end
          end
          S_DONE:
          begin
            res_wr     <= 1'b1;
            res_val    <= best_boost;
            timer      <= 12'h000;
            manual_dfe <= 1'b0;
            st         <= (!pass && mode[MODE_MSB - MODE_LSB]) ? S_DFE : S_ACQ;
          end
          S_DFE:
          begin
            timer <= timer + 12'h001;
            if (ch_in[c].dfe_done || (timer == DFE_CYC - 12'h001))
            begin
              pass <= 1'b1;
              st   <= manual_dfe ? S_ACQ : S_START;
            end
          end
          S_LOCK:
          begin
            if (!ph_s2 || (cfg[c][I_EYE_MON][EYE_MON_BIT] && ch_in[c].eye_valid && !eye_ok) ||
                (win_done && (abs_diff(win_count, lock_count) > DRIFT_TOL)))
            begin
              lol_q     <= 1'b1;
              restart_q <= 1'b1;
              pass      <= 1'b0;
              st        <= adapt_on ? S_START : S_ACQ;
            end
          end
          default: st <= S_CAL;
        endcase
        if (ctle_trig)
        begin
          pass <= 1'b1;
          st   <= S_START;
        end
        if (dfe_trig)
        begin
          manual_dfe <= 1'b1;
          timer      <= 12'h000;
          st         <= S_DFE;
        end
        if (cdr_rst)
        begin
          restart_q <= 1'b1;
          pass      <= 1'b0;
          st        <= adapt_on ? S_START : S_ACQ;
        end
        if (soft_rst)
          st <= S_CAL;
      end
    end

    ealc_boost_table u_table (
      .ref_clk_in    (ref_clk_in),
      .nrst_in       (nrst_in),
      .restore_in    (soft_rst),
      .wr_en_in      (wr_here && tbl_hit),
      .wr_addr_in    (reg_req_in.addr[4:0]),
      .wr_data_in    (reg_req_in.wdata),
      .rd_a_addr_in  (reg_req_in.addr[4:0]),
      .rd_a_data_out (tbl_bus_q[c]),
      .rd_b_addr_in  (idx),
      .rd_b_data_out (tbl_q)
    );

    // Registered channel outputs.
    always_ff @(posedge ref_clk_in)
    begin
      if (!nrst_in)
        ch_out[c] <= '0;
      else
      begin
        ch_out[c].boost          <= ((st == S_TRY) || (st == S_MEAS)) ? tbl_q : cfg[c][I_BOOST_RES];
        ch_out[c].dfe_hold       <= (mode == MODE_NONE);
        ch_out[c].dfe_zero_taps  <= (mode == MODE_CTLE);
        ch_out[c].dfe_adapt_req  <= (st == S_DFE);
        ch_out[c].tap_limit4     <= cfg[c][I_TAP_LIM4][LIM4_MSB:0];
        ch_out[c].tap_limit5     <= cfg[c][I_TAP_LIM5][LIM5_MSB:0];
        ch_out[c].locked         <= (st == S_LOCK);
        ch_out[c].lol_irq        <= lol_q;
        ch_out[c].vco_cal_active <= (st == S_CAL);
        ch_out[c].cdr_restart    <= restart_q;
        ch_out[c].ref_mode       <= cfg[c][I_REF_MODE][REF_MSB:REF_LSB];
      end
    end
  end

endmodule

//--- rtl/ealc_pkg.sv
// Shared constants, types and helpers for the equalizer adaptation and lock controller.
package ealc_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int          NCH      = 4;
  localparam int          NREG     = 13;
  localparam int          TBL_N    = 32;
  localparam logic [4:0]  IDX_MAX  = 5'h1F;
  localparam logic [4:0]  IDX_ZERO = 5'h00;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] A_CH_RESET   = 8'h00;
  localparam logic [7:0] A_BOOST_RES  = 8'h03;
  localparam logic [7:0] A_CDR_CTRL   = 8'h0A;
  localparam logic [7:0] A_DFE_TRIG   = 8'h24;
  localparam logic [7:0] A_LOOK_BEY   = 8'h2C;
  localparam logic [7:0] A_RATE_TRIG  = 8'h2F;
  localparam logic [7:0] A_ADAPT_SEL  = 8'h31;
  localparam logic [7:0] A_TAP_LIM4   = 8'h34;
  localparam logic [7:0] A_TAP_LIM5   = 8'h35;
  localparam logic [7:0] A_REF_MODE   = 8'h36;
  localparam logic [7:0] A_START_IDX  = 8'h39;
  localparam logic [7:0] A_EYE_MON    = 8'h3E;
  localparam logic [7:0] A_EYE_THR    = 8'h6A;
  localparam logic [7:0] A_TBL_FIRST  = 8'h40;
  localparam logic [7:0] A_TBL_LAST   = 8'h5F;

  // Storage slot of each register.
  localparam logic [3:0] I_CH_RESET  = 4'h0;
  localparam logic [3:0] I_BOOST_RES = 4'h1;
  localparam logic [3:0] I_CDR_CTRL  = 4'h2;
  localparam logic [3:0] I_DFE_TRIG  = 4'h3;
  localparam logic [3:0] I_LOOK_BEY  = 4'h4;
  localparam logic [3:0] I_RATE_TRIG = 4'h5;
  localparam logic [3:0] I_ADAPT_SEL = 4'h6;
  localparam logic [3:0] I_TAP_LIM4  = 4'h7;
  localparam logic [3:0] I_TAP_LIM5  = 4'h8;
  localparam logic [3:0] I_REF_MODE  = 4'h9;
  localparam logic [3:0] I_START_IDX = 4'hA;
  localparam logic [3:0] I_EYE_MON   = 4'hB;
  localparam logic [3:0] I_EYE_THR   = 4'hC;
  localparam logic [3:0] I_NONE      = 4'hF;

  localparam logic [7:0] CFG_RESET [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h20,
                                              8'h0F, 8'h1F, 8'h30, 8'h00, 8'h80, 8'h22};

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CH_RST_BIT    = 2;
  localparam int CDR_RST_MSB   = 3;
  localparam int CDR_RST_LSB   = 2;
  localparam int DFE_TRIG_BIT  = 2;
  localparam int CTLE_TRIG_BIT = 0;
  localparam int START_OVR_BIT = 3;
  localparam int MODE_MSB      = 6;
  localparam int MODE_LSB      = 5;
  localparam int LB_MSB        = 3;
  localparam int LB_LSB        = 0;
  localparam int LIM4_MSB      = 3;
  localparam int LIM5_MSB      = 4;
  localparam int START_MSB     = 4;
  localparam int REF_MSB       = 5;
  localparam int REF_LSB       = 4;
  localparam int EYE_MON_BIT   = 7;
  localparam int THR_H_MSB     = 7;
  localparam int THR_H_LSB     = 4;
  localparam int THR_V_MSB     = 3;
  localparam int THR_V_LSB     = 0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_MHZ    = 50;
  localparam int          SETTLE_NS  = 2000;
  localparam int          EYE_WAIT_NS = 20000;
  localparam int          DFE_WAIT_NS = 80000;
  localparam int          WINDOW_NS  = 10240;
  localparam logic [11:0] SETTLE_CYC = 12'((SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] EYE_CYC    = 12'((EYE_WAIT_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] DFE_CYC    = 12'((DFE_WAIT_NS * CLK_MHZ) / 1000);
  localparam logic [9:0]  WIN_CYC    = 10'((WINDOW_NS * CLK_MHZ) / 1000);
  localparam logic [9:0]  SPUR_TOL   = 10'h004;
  localparam logic [9:0]  DRIFT_TOL  = 10'h004;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NONE     = 2'b00,
    MODE_CTLE     = 2'b01,
    MODE_OPT_DFE  = 2'b10,
    MODE_LOCK_DFE = 2'b11
  } ealc_mode_e;

  typedef enum logic [2:0] {
    S_CAL   = 3'b000,
    S_ACQ   = 3'b001,
    S_START = 3'b010,
    S_TRY   = 3'b011,
    S_MEAS  = 3'b100,
    S_DONE  = 3'b101,
    S_DFE   = 3'b110,
    S_LOCK  = 3'b111
  } ealc_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] ch;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ealc_reg_req_s;

  typedef struct packed {
    logic       phase_lock;
    logic       vco_div;
    logic       eye_valid;
    logic [7:0] horizontal_eye_width;
    logic [7:0] vertical_eye_height;
    logic       dfe_done;
  } ealc_ch_in_s;

  typedef struct packed {
    logic [7:0] boost;
    logic       dfe_hold;
    logic       dfe_zero_taps;
    logic       dfe_adapt_req;
    logic [3:0] tap_limit4;
    logic [4:0] tap_limit5;
    logic       locked;
    logic       lol_irq;
    logic       vco_cal_active;
    logic       cdr_restart;
    logic [1:0] ref_mode;
  } ealc_ch_out_s;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] reg_idx(input logic [7:0] a);
    case (a)
      A_CH_RESET:  reg_idx = I_CH_RESET;
      A_BOOST_RES: reg_idx = I_BOOST_RES;
      A_CDR_CTRL:  reg_idx = I_CDR_CTRL;
      A_DFE_TRIG:  reg_idx = I_DFE_TRIG;
      A_LOOK_BEY:  reg_idx = I_LOOK_BEY;
      A_RATE_TRIG: reg_idx = I_RATE_TRIG;
      A_ADAPT_SEL: reg_idx = I_ADAPT_SEL;
      A_TAP_LIM4:  reg_idx = I_TAP_LIM4;
      A_TAP_LIM5:  reg_idx = I_TAP_LIM5;
      A_REF_MODE:  reg_idx = I_REF_MODE;
      A_START_IDX: reg_idx = I_START_IDX;
      A_EYE_MON:   reg_idx = I_EYE_MON;
      A_EYE_THR:   reg_idx = I_EYE_THR;
      default:     reg_idx = I_NONE;
    endcase
  endfunction

  function automatic logic [9:0] abs_diff(input logic [9:0] a, input logic [9:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  localparam logic [7:0] BOOST_DEFAULT [TBL_N] = '{
    8'h00, 8'h01, 8'h04, 8'h10, 8'h40, 8'h08, 8'h02, 8'h80,
    8'h03, 8'h0C, 8'h30, 8'h41, 8'h50, 8'hC0, 8'h60, 8'h90,
    8'h88, 8'h82, 8'hA0, 8'h46, 8'h52, 8'h8C, 8'hB0, 8'hC8,
    8'h57, 8'h5D, 8'h69, 8'h75, 8'hD5, 8'h99, 8'h96, 8'hA5};

endpackage

//--- rtl/ealc_boost_table.sv
// Candidate boost table of one channel, two registered read ports.
`timescale 1ns/1ps
module ealc_boost_table (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       restore_in,
  // Write port
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  // Read ports
  input  wire logic [4:0] rd_a_addr_in,
  output logic      [7:0] rd_a_data_out,
  input  wire logic [4:0] rd_b_addr_in,
  output logic      [7:0] rd_b_data_out
);
  import ealc_pkg::*;

  logic [7:0] mem [TBL_N];

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in || restore_in)
    begin
      for (int i = 0; i < TBL_N; i++)
        mem[i] <= BOOST_DEFAULT[i];
    end
    else if (wr_en_in)
      mem[wr_addr_in] <= wr_data_in;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      rd_a_data_out <= 8'h00;
      rd_b_data_out <= 8'h00;
    end
    else
    begin
      rd_a_data_out <= mem[rd_a_addr_in];
      rd_b_data_out <= mem[rd_b_addr_in];
    end
  end

endmodule

//--- verification/ealc_checker.sv
// Concurrent checks of register answers, mode flags and lock loss on channel 0.
`timescale 1ns/1ps
module ealc_checker (
  // Clock and reset
  input wire logic                                       ref_clk_in,
  input wire logic                                       nrst_in,
  // Register port
  input wire ealc_pkg::ealc_reg_req_s                    reg_req_in,
  input wire logic [7:0]                                 reg_rdata_out,
  input wire logic                                       reg_rvalid_out,
  // Channel side
  input wire ealc_pkg::ealc_ch_in_s  [ealc_pkg::NCH-1:0] ch_in,
  input wire ealc_pkg::ealc_ch_out_s [ealc_pkg::NCH-1:0] ch_out
);
  import ealc_pkg::*;
  ealc_ch_out_s o;
  logic [2:0]   wh;
  logic         w5;
  assign o  = ch_out[0];
  assign w5 = reg_req_in.wr && reg_req_in.ch == 2'h0 && reg_req_in.addr == A_TAP_LIM5;
  // Recent write strobes, so that a host write to the boost register is not taken for drift.
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      wh <= 3'h0;
    else
      wh <= {wh[1:0], reg_req_in.wr};
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  a_rd_answer: assert property (reg_req_in.rd |-> ##2 reg_rvalid_out) else $error("read unanswered");
  a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_req_in.rd, 2)) else $error("stray rvalid");
  a_lim5_follow: assert property (w5 |-> ##3 o.tap_limit5 == $past(reg_req_in.wdata[4:0], 3)) else $error("limit");
  a_hold_boost: assert property (o.dfe_hold && $past(o.dfe_hold) && wh == 3'h0 |-> $stable(o.boost)) else $error("boost");
  a_zero_taps: assert property (reg_req_in.wr && reg_req_in.ch == 2'h0 && reg_req_in.addr == A_ADAPT_SEL |->
    ##2 o.dfe_zero_taps == ($past(reg_req_in.wdata[MODE_MSB:MODE_LSB], 2) == 2'b01)) else $error("zero taps");
  a_lol_pulse: assert property (o.lol_irq |=> !o.lol_irq && !o.locked) else $error("loss pulse");
  a_phase_loss: assert property ($fell(ch_in[0].phase_lock) && o.locked |-> ##[1:8] o.lol_irq) else $error("no loss");
  a_lol_restart: assert property (o.lol_irq |-> ##[0:8] o.cdr_restart) else $error("no restart");
  c_lock: cover property ($rose(o.locked));
  c_loss: cover property (o.lol_irq);
  c_dfe: cover property ($rose(o.dfe_adapt_req));
endmodule
bind ealc_top ealc_checker u_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .ch_in(ch_in), .ch_out(ch_out));

//--- verification/ealc_far_model.sv
// Far-side channel model: phase lock, eye monitor, divided oscillator, feedback engine.
`timescale 1ns/1ps
module ealc_far_model (
  // Controls from the bench
  input  wire logic                                       ref_clk_in,
  input  wire logic                                       lock_in,
  input  wire logic                                       eye_good_in,
  input  wire logic [3:0]                                 vco_half_in,
  // Channel side
  input  wire ealc_pkg::ealc_ch_out_s [ealc_pkg::NCH-1:0] ch_out_in,
  output ealc_pkg::ealc_ch_in_s       [ealc_pkg::NCH-1:0] ch_in_out
);
  import ealc_pkg::*;
  logic [7:0] tick = 8'h00;
  logic [3:0] cnt  = 4'h1;
  logic       vco  = 1'b0;
  logic [7:0] eye;
  logic       ev;
  assign ev  = lock_in && tick[5:0] == 6'h3F;
  // Between measurements the eye lines carry a moving pattern, not the last value.
  assign eye = ev ? (eye_good_in ? 8'h60 : 8'h10) : tick;
  always_ff @(posedge ref_clk_in)
  begin
    tick <= tick + 8'h01;
    cnt  <= (cnt >= vco_half_in) ? 4'h1 : cnt + 4'h1;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (cnt >= vco_half_in)
      vco <= ~vco;
  end
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      ch_in_out[i] = '{lock_in, vco, ev, eye, eye, ch_out_in[i].dfe_adapt_req && tick[5:0] == 6'h20};
  end
endmodule

//--- verification/ealc_top_tb_top.sv
// Self-checking bench of the adaptation and lock controller.
`timescale 1ns/1ps
module ealc_top_tb_top;
  import ealc_pkg::*;
  logic                   clk    = 1'b0;
  logic                   rst_n  = 1'b0;
  ealc_reg_req_s          req    = '0;
  logic [7:0]             rdata;
  logic                   rvalid;
  ealc_ch_in_s  [NCH-1:0] chi;
  ealc_ch_out_s [NCH-1:0] cho;
  logic                   lock   = 1'b1;
  logic                   eye    = 1'b1;
  logic [3:0]             half   = 4'h8;
  logic [7:0]             v;
  logic [7:0]             ra [8] = '{8'h31, 8'h2C, 8'h36, 8'h3E, 8'h6A, 8'h34, 8'h35, 8'h7F};
  logic [7:0]             rv [8] = '{8'h20, 8'h32, 8'h30, 8'h80, 8'h22, 8'h0F, 8'h1F, 8'h00};
  int                     errors = 0;
  int                     checks = 0;
  initial forever #10 clk = ~clk;
  ealc_top dut (.ref_clk_in(clk), .nrst_in(rst_n), .reg_req_in(req), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .ch_in(chi), .ch_out(cho));
  ealc_far_model far (.ref_clk_in(clk), .lock_in(lock), .eye_good_in(eye), .vco_half_in(half),
    .ch_out_in(cho), .ch_in_out(chi));
  function automatic logic [3:0] lim4(input logic [7:0] d);
    lim4 = d[3:0];
  endfunction
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic close_out;
    $display("Counts: checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] c, input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, c, a, d};
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [1:0] c, input logic [7:0] a, input logic [7:0] e, input string m);
    req = '{1'b0, 1'b1, c, a, 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    @(negedge clk);
    chk(rvalid === 1'b1 && rdata === e, m);
  endtask
  task automatic wt(input logic dfe, input logic lvl, input int lim, input string m);
    int n = 0;
    while (((dfe ? cho[0].dfe_adapt_req : cho[0].locked) !== lvl) && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk(n < lim, m);
  endtask
  initial
  begin
    #1000000;
    errors++;
    close_out();
  end
  initial
  begin
    v = 8'($urandom(68));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(cho[0].vco_cal_active === 1'b1, "calibrating");
    foreach (ra[i]) rd(2'h0, ra[i], rv[i], "reset value");
    v = 8'($urandom);
    wr(2'h1, 8'h6A, v);
    rd(2'h1, 8'h6A, v, "ch1 threshold");
    rd(2'h0, 8'h6A, 8'h22, "ch0 threshold");
    wr(2'h1, 8'h45, v);
    rd(2'h1, 8'h45, v, "table write");
    wr(2'h1, 8'h00, 8'h04);
    @(negedge clk);
    rd(2'h1, 8'h45, BOOST_DEFAULT[5], "table default");
    $display("test done: registers");
    v = 8'($urandom);
    wr(2'h0, 8'h34, v);
    wr(2'h0, 8'h35, v);
    wr(2'h0, 8'h40, v);
    wr(2'h0, 8'h36, 8'h30);
    repeat (3) @(negedge clk);
    chk(cho[0].tap_limit4 === lim4(v) && cho[0].ref_mode === 2'b11, "limit");
    chk(cho[0].tap_limit5 === v[4:0], "limit5");
    chk(cho[0].dfe_zero_taps === 1'b1, "zero taps");
    wt(1'b0, 1'b1, 20000, "lock");
    rd(2'h0, 8'h03, v, "boost result");
    eye = 1'b0;
    wt(1'b0, 1'b0, 200, "eye loss");
    eye = 1'b1;
    wt(1'b0, 1'b1, 20000, "relock");
    wr(2'h0, 8'h3E, 8'h00);
    eye = 1'b0;
    repeat (500) @(negedge clk);
    chk(cho[0].locked === 1'b1, "monitor off");
    eye = 1'b1;
    wr(2'h0, 8'h3E, 8'h80);
    lock = 1'b0;
    wt(1'b0, 1'b0, 20, "phase loss");
    lock = 1'b1;
    wt(1'b0, 1'b1, 20000, "relock");
    $display("test done: lock");
    half = 4'h6;
    wt(1'b0, 1'b0, 2000, "drift loss");
    repeat (3000) @(negedge clk);
    chk(cho[0].locked === 1'b0, "spur lock");
    half = 4'h8;
    wt(1'b0, 1'b1, 30000, "relock");
    $display("test done: reference");
    wr(2'h0, 8'h24, 8'h04);
    repeat (4) @(negedge clk);
    chk(cho[0].dfe_adapt_req === 1'b0, "set only");
    wr(2'h0, 8'h24, 8'h00);
    wt(1'b1, 1'b1, 10, "dfe start");
    wt(1'b1, 1'b0, 100, "dfe end");
    wt(1'b0, 1'b1, 200, "dfe relock");
    v = 8'($urandom % 31) + 8'h01;
    wr(2'h0, 8'h39, v);
    wr(2'h0, 8'h2F, 8'h09);
    chk(cho[0].locked === 1'b1, "set only ctle");
    wr(2'h0, 8'h2F, 8'h08);
    wt(1'b0, 1'b0, 10, "ctle start");
    wt(1'b0, 1'b1, 20000, "ctle relock");
    rd(2'h0, 8'h03, BOOST_DEFAULT[v[4:0]], "start index");
    wr(2'h0, 8'h31, 8'h60);
    wr(2'h0, 8'h0A, 8'h0C);
    wt(1'b1, 1'b1, 3000, "auto dfe");
    wt(1'b1, 1'b0, 200, "auto dfe end");
    wt(1'b0, 1'b1, 20000, "mode 3 relock");
    for (int m = 3; m >= 0; m--)
    begin
      wr(2'h0, 8'h31, {1'b0, 2'(m), 5'h00});
      repeat (3) @(negedge clk);
      chk(cho[0].dfe_hold === (m == 0) && cho[0].dfe_zero_taps === (m == 1), "mode");
    end
    v = 8'($urandom);
    wr(2'h0, 8'h03, v);
    repeat (4) @(negedge clk);
    chk(cho[0].boost === v, "manual boost");
    $display("test done: modes");
    close_out();
  end
endmodule
